// ==== tadc_host_model.sv ====
// host side model: frames control bytes and collects results
module tadc_host_model (
  input  wire logic ref_clk_i, // system clock
  input  wire logic dout_i,    // result bit
  input  wire logic dout_oe_i, // result line driven
  output logic      cs_n_o,    // select, active low
  output logic      sclk_o,    // serial and conversion clock
  output logic      din_o      // control bits
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 4; // half period in system cycles, above the sync latency
  initial begin
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    din_o  = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  // clock stays low between frames; fewer than 21 clocks cuts the result short
  task automatic xfer(input logic [6:0] ctrl, input int nclk, output logic [11:0] res);
    res = 12'hXXX;
    cs_n_o = 1'h0;
    tick(HALF);
    for (int i = 0; i < nclk; i++) begin
      din_o = (i == 0) ? 1'h1 : (i < 8) ? ctrl[7 - i] : 1'h0;
      tick(HALF);
      sclk_o = 1'h1;
      tick(HALF);
      // a floating line reads unknown, never a lucky match
      if (i >= 9 && i <= 20) res[20 - i] = dout_oe_i ? dout_i : 1'hX;
      sclk_o = 1'h0;
    end
    tick(HALF);
    cs_n_o = 1'h1;
    tick(2 * HALF);
  endtask : xfer
endmodule : tadc_host_model

// ==== tadc_pin_if.sv ====
// synchronised pin view passed from the pin synchroniser to the port logic
interface tadc_pin_if;
  logic        cs_n;       // select, active low
  logic        din;        // serial data in
  logic        shift_and_convert_clock_rise;  // one-cycle pulse on a rising serial clock
  logic        shift_and_convert_clock_fall;  // one-cycle pulse on a falling serial clock
  logic        pen;        // pen touching panel
  logic [11:0] x_pos;      // sampled analog stand-ins
  logic [11:0] y_pos;
  logic [11:0] aux_a;
  logic [11:0] aux_b;
  modport src (output cs_n, din, shift_and_convert_clock_rise, shift_and_convert_clock_fall, pen, x_pos, y_pos, aux_a, aux_b);
  modport dst (input  cs_n, din, shift_and_convert_clock_rise, shift_and_convert_clock_fall, pen, x_pos, y_pos, aux_a, aux_b);
endinterface : tadc_pin_if

// ==== tadc_pin_sync.sv ====
// two-flop synchronisers and serial clock edge detection
module tadc_pin_sync (
  input  wire logic        ref_clk_i,       // system clock
  input  wire logic        rst_i,           // synchronous reset, active high
  input  wire logic        cs_n_i,          // select pin, active low
  input  wire logic        shift_and_convert_clock_i, // serial clock pin
  input  wire logic        din_i,           // serial data pin
  input  wire logic        pen_touch_i,     // pen contact level
  input  wire logic [11:0] x_pos_i,         // x panel level
  input  wire logic [11:0] y_pos_i,         // y panel level
  input  wire logic [11:0] aux_input_a_i,   // auxiliary level a
  input  wire logic [11:0] aux_input_b_i,   // auxiliary level b
  tadc_pin_if.src          pins             // synchronised view
);
  typedef struct packed {
    logic [tadc_pkg::SYNC_W-1:0] s1;
    logic [tadc_pkg::SYNC_W-1:0] s2;
    logic                        shift_and_convert_clock_prev;
  } tadc_sync_type;

  tadc_sync_type q, d;

  // first stage is read only by the second stage; edges come from stage two
  always_comb begin
    d           = q;
    d.s1        = {cs_n_i, shift_and_convert_clock_i, din_i, pen_touch_i,
                   x_pos_i, y_pos_i, aux_input_a_i, aux_input_b_i};
    d.s2        = q.s1;
    d.shift_and_convert_clock_prev = q.s2[tadc_pkg::SYNC_W-2];
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '{s1: {1'b1, {(tadc_pkg::SYNC_W-1){1'b0}}},
             s2: {1'b1, {(tadc_pkg::SYNC_W-1){1'b0}}},
             shift_and_convert_clock_prev: 1'b0};
    end else begin
      q <= d;
    end
  end

  // serial clock is slow against ref_clk, so edges are plain level compares
  assign pins.cs_n      = q.s2[tadc_pkg::SYNC_W-1];
  assign pins.din       = q.s2[tadc_pkg::SYNC_W-3];
  assign pins.pen       = q.s2[tadc_pkg::SYNC_W-4];
  assign pins.shift_and_convert_clock_rise = q.s2[tadc_pkg::SYNC_W-2] & ~q.shift_and_convert_clock_prev;
  assign pins.shift_and_convert_clock_fall = ~q.s2[tadc_pkg::SYNC_W-2] & q.shift_and_convert_clock_prev;
  assign pins.x_pos     = q.s2[47:36];
  assign pins.y_pos     = q.s2[35:24];
  assign pins.aux_a     = q.s2[23:12];
  assign pins.aux_b     = q.s2[11:0];
endmodule : tadc_pin_sync

// ==== tadc_pkg.sv ====
// shared constants and types of the touch digitizer serial port
package tadc_pkg;
  localparam int unsigned RESULT_W      = 12;          // result width in bits
  localparam int unsigned CTRL_W        = 7;           // control bits after the start bit
  localparam int unsigned CNT_W         = 5;           // width of the falling edge counter
  localparam int unsigned SYNC_W        = 4 + 4 * RESULT_W; // pins plus four analog samples
  localparam logic [4:0]  FALL_TRACK    = 5'h05;       // falling edge that starts tracking
  localparam logic [4:0]  ACQ_CYCLES    = 5'h03;       // clocks given to acquisition
  localparam logic [4:0]  FALL_HOLD     = FALL_TRACK + ACQ_CYCLES; // hold point
  localparam logic [4:0]  RESULT_FALLS  = 5'h0C;       // falls that carry result bits
  localparam logic [4:0]  CNT_RST       = 5'h00;       // counter value after reset
  localparam logic [6:0]  CTRL_RST      = 7'h00;       // control register after reset
  localparam logic [11:0] RESULT_RST    = 12'h000;     // result register after reset
  localparam logic [11:0] FIXED_CODE    = 12'h800;     // fixed pattern of differential code 110
  localparam logic [11:0] LOW4_MASK     = 12'hFF0;     // keeps eight bits in 8-bit mode
  // control register field positions, first received bit highest
  localparam int unsigned BIT_ADDR2     = 6;
  localparam int unsigned BIT_ADDR1     = 5;
  localparam int unsigned BIT_ADDR0     = 4;
  localparam int unsigned BIT_MODE8     = 3;
  localparam int unsigned BIT_REF_MODE  = 2;
  // channel address codes
  localparam logic [2:0]  ADDR_X_POS    = 3'h1;
  localparam logic [2:0]  ADDR_AUX_A    = 3'h2;
  localparam logic [2:0]  ADDR_Y_POS    = 3'h5;
  localparam logic [2:0]  ADDR_AUX_B    = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CTRL = 2'b01,
    ST_CONV = 2'b10
  } tadc_state_type;
endpackage : tadc_pkg

// ==== tadc_serial_port.sv ====
// serial control and result port of a 12-bit touch screen digitizer
module tadc_serial_port (
  input  wire logic        ref_clk_i,                 // 10 MHz system clock
  input  wire logic        rst_i,                     // synchronous reset, active high
  input  wire logic        cs_n_i,                    // select pin, active low
  input  wire logic        shift_and_convert_clock_i, // serial and conversion clock pin
  input  wire logic        din_i,                     // serial data in pin
  input  wire logic        pen_touch_i,               // pen contact level
  input  wire logic [11:0] x_pos_i,                   // x panel converter level
  input  wire logic [11:0] y_pos_i,                   // y panel converter level
  input  wire logic [11:0] aux_input_a_i,             // auxiliary input a level
  input  wire logic [11:0] aux_input_b_i,             // auxiliary input b level
  output logic             dout_o,                    // serial data out value
  output logic             dout_oe_o,                 // serial data out enable
  output logic             busy_o,                    // busy value
  output logic             busy_oe_o,                 // busy enable
  output logic             touch_irq_out_o,           // interrupt value, always low
  output logic             touch_irq_oe_o,            // interrupt pulls low when high
  output logic             track_o                    // track-and-hold acquiring
);
  // whole port state in one register; pin effects land three ref clock edges late
  typedef struct packed {
    tadc_pkg::tadc_state_type state;
    logic [4:0]               fall_cnt;
    logic [6:0]               ctrl;
    logic [11:0]              result;
    logic                     dout;
    logic                     dout_oe;
    logic                     busy;
    logic                     busy_oe;
    logic                     irq_lvl;
    logic                     irq_oe;
    logic                     track;
  } tadc_port_type;

  tadc_port_type q, d;
  tadc_pin_if    pins ();

  // pins pass two flops here, so the sequencer never reads a metastable level
  tadc_pin_sync u_sync (
    .ref_clk_i                 (ref_clk_i),
    .rst_i                     (rst_i),
    .cs_n_i                    (cs_n_i),
    .shift_and_convert_clock_i (shift_and_convert_clock_i),
    .din_i                     (din_i),
    .pen_touch_i               (pen_touch_i),
    .x_pos_i                   (x_pos_i),
    .y_pos_i                   (y_pos_i),
    .aux_input_a_i             (aux_input_a_i),
    .aux_input_b_i             (aux_input_b_i),
    .pins                      (pins)
  );

  // input multiplexer; invalid addresses give zero
  // the sample is taken once at the hold point, so later pin moves cannot tear a result
  function automatic logic [11:0] pick_input(
      input logic [6:0]  ctrl, // captured control byte
      input logic [11:0] xp,   // x panel sample
      input logic [11:0] yp,   // y panel sample
      input logic [11:0] aa,   // auxiliary a sample
      input logic [11:0] ab);  // auxiliary b sample
    logic [2:0]  addr;
    logic        single;
    logic        narrow;
    logic [11:0] val;
    addr   = {ctrl[tadc_pkg::BIT_ADDR2], ctrl[tadc_pkg::BIT_ADDR1], ctrl[tadc_pkg::BIT_ADDR0]};
    single = ctrl[tadc_pkg::BIT_REF_MODE];
    narrow = ctrl[tadc_pkg::BIT_MODE8];
    val    = tadc_pkg::RESULT_RST;
    case (addr)
      tadc_pkg::ADDR_X_POS: begin
        val = xp;
      end
      tadc_pkg::ADDR_Y_POS: begin
        val = yp;
      end
      tadc_pkg::ADDR_AUX_A: begin
        // the first auxiliary input has no differential pairing
        val = single ? aa : tadc_pkg::RESULT_RST;
      end
      tadc_pkg::ADDR_AUX_B: begin
        val = single ? ab : tadc_pkg::FIXED_CODE;
      end
      default: begin
        val = tadc_pkg::RESULT_RST; // invalid addresses read as zero
      end
    endcase
    // 8-bit mode keeps the top eight bits; the low four read as zero
    if (narrow) begin
      val = val & tadc_pkg::LOW4_MASK;
    end
    return val;
  endfunction : pick_input

  // next falling edge count; saturates so a long tail of zero bits cannot wrap
  function automatic logic [4:0] inc_fall(input logic [4:0] cnt);
    logic [4:0] nxt;
    nxt = cnt;
    if (cnt != 5'h1F) begin
      nxt = cnt + 5'h01;
    end
    return nxt;
  endfunction : inc_fall

  // a start bit is a serial clock rise that finds the data line high
  function automatic logic start_bit(input logic rise, input logic data);
    return rise & data;
  endfunction : start_bit

  // port sequencer; every step except the deselect abort and the pad enable and interrupt updates is paced by serial clock edges
  always_comb begin
    d         = q;
    // pad enables and the interrupt follow their pins every cycle, in any state
    d.dout_oe = ~pins.cs_n;
    d.busy_oe = ~pins.cs_n;
    d.irq_lvl = 1'b0;
    d.irq_oe  = pins.pen;
    if (pins.cs_n) begin
      // select high abandons any exchange, the host must avoid it mid-transfer
      d.state    = tadc_pkg::ST_IDLE;
      d.fall_cnt = tadc_pkg::CNT_RST;
      d.busy     = 1'b0;
      d.dout     = 1'b0;
      d.track    = 1'b0;
    end else begin
      // the state only moves on synchronised serial clock edges
      unique case (q.state)
        tadc_pkg::ST_IDLE: begin
          // counting restarts so that fall 1 is the first fall after the start bit
          if (start_bit(pins.shift_and_convert_clock_rise, pins.din)) begin
            d.state    = tadc_pkg::ST_CTRL;
            d.fall_cnt = tadc_pkg::CNT_RST;
          end
        end
        tadc_pkg::ST_CTRL: begin
          // the start rise itself finds count zero and is not a control bit
          if (pins.shift_and_convert_clock_rise && q.fall_cnt != tadc_pkg::CNT_RST) begin
            d.ctrl = {q.ctrl[5:0], pins.din};
          end
          if (pins.shift_and_convert_clock_fall) begin
            d.fall_cnt = inc_fall(q.fall_cnt);
            if (d.fall_cnt == tadc_pkg::FALL_TRACK) begin
              d.track = 1'b1;
            end
            if (d.fall_cnt == tadc_pkg::FALL_HOLD) begin
              // hold after three clocks of tracking; result in straight binary
              d.track    = 1'b0;
              d.busy     = 1'b1;
              d.result   = pick_input(q.ctrl, pins.x_pos, pins.y_pos, pins.aux_a,
                                      pins.aux_b);
              d.state    = tadc_pkg::ST_CONV;
              d.fall_cnt = tadc_pkg::CNT_RST;
            end
          end
        end
        tadc_pkg::ST_CONV: begin
          if (pins.shift_and_convert_clock_fall) begin
            // msb first, zeros follow once the result is exhausted
            d.busy   = 1'b0;
            d.dout   = q.result[11];
            d.result = {q.result[10:0], 1'b0};
            d.fall_cnt = inc_fall(q.fall_cnt);
          end else if (start_bit(pins.shift_and_convert_clock_rise, pins.din) &&
                       q.fall_cnt >= tadc_pkg::RESULT_FALLS) begin
            // a new start bit is accepted only after all result bits went out
            d.state    = tadc_pkg::ST_CTRL;
            d.fall_cnt = tadc_pkg::CNT_RST;
          end
        end
        default: begin
          d.state = tadc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // single register stage for the whole port; reset leaves every pad released
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '{state:    tadc_pkg::ST_IDLE,
             fall_cnt: tadc_pkg::CNT_RST,
             ctrl:     tadc_pkg::CTRL_RST,
             result:   tadc_pkg::RESULT_RST,
             dout:     1'b0,
             dout_oe:  1'b0,
             busy:     1'b0,
             busy_oe:  1'b0,
             irq_lvl:  1'b0,
             irq_oe:   1'b0,
             track:    1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  // serial pads: value and enable leave the same flop stage together
  assign dout_o          = q.dout;
  assign dout_oe_o       = q.dout_oe;
  assign busy_o          = q.busy;
  assign busy_oe_o       = q.busy_oe;

  // open drain: the value is held low and only the enable moves
  assign touch_irq_out_o = q.irq_lvl;
  assign touch_irq_oe_o  = q.irq_oe;

  // observation only, not a pad of the device
  assign track_o         = q.track;
endmodule : tadc_serial_port

// ==== tadc_serial_port_monitor.sv ====
// assertion checker for the touch digitizer serial port pins
module tadc_serial_port_monitor (
  input wire logic ref_clk_i,                 // system clock
  input wire logic rst_i,                     // synchronous reset
  input wire logic cs_n_i,                    // select pin, active low
  input wire logic shift_and_convert_clock_i, // serial clock pin
  input wire logic pen_touch_i,               // pen contact level
  input wire logic dout_o,                    // serial result bit
  input wire logic dout_oe_o,                 // result enable
  input wire logic busy_o,                    // busy value
  input wire logic busy_oe_o,                 // busy enable
  input wire logic touch_irq_out_o,           // interrupt value
  input wire logic touch_irq_oe_o,            // interrupt enable
  input wire logic track_o                    // acquiring
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sclk_q;    // serial clock as last sampled
  logic [3:0] fall_q;    // recent pin falls, newest in bit 0
  logic [2:0] trk_cnt_q; // falls seen while tracking
  logic [2:0] bsy_cnt_q; // falls seen while busy
  logic       fall_now;
  logic       fall_win;
  // answers land three cycles after a pin fall; one cycle slack each way
  assign fall_now = sclk_q & ~shift_and_convert_clock_i;
  assign fall_win = |fall_q[3:1];
  // fall history and per-phase fall counters
  always_ff @(posedge ref_clk_i) begin
    sclk_q    <= shift_and_convert_clock_i;
    fall_q    <= {fall_q[2:0], fall_now};
    trk_cnt_q <= !track_o ? 3'h0 : trk_cnt_q + {2'h0, fall_now};
    bsy_cnt_q <= !busy_o ? 3'h0 : bsy_cnt_q + {2'h0, fall_now};
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_dout_float: assert property (cs_n_i [*4] |-> !dout_oe_o)
    else $error("data line driven while deselected");
  a_busy_float: assert property (cs_n_i [*4] |-> !busy_oe_o)
    else $error("busy line driven while deselected");
  a_select_drive: assert property (!cs_n_i [*4] |-> dout_oe_o && busy_oe_o)
    else $error("outputs not driven while selected");
  a_shift_on_fall: assert property (
      $past(dout_oe_o) && dout_oe_o && $changed(dout_o) |-> fall_win)
    else $error("result bit moved without a serial fall");
  a_track_start: assert property ($rose(track_o) |-> fall_win)
    else $error("tracking began off a serial fall");
  a_track_len: assert property (
      disable iff (rst_i || cs_n_i) $fell(track_o) |-> trk_cnt_q == 3'h3)
    else $error("acquisition not three serial clocks");
  a_busy_start: assert property ($rose(busy_o) |-> fall_win)
    else $error("busy rose off a serial fall");
  a_busy_len: assert property (
      disable iff (rst_i || cs_n_i) $fell(busy_o) |-> bsy_cnt_q == 3'h1)
    else $error("busy not one serial clock");
  a_irq_follow: assert property (pen_touch_i [*4] |-> touch_irq_oe_o)
    else $error("touch not reported");
  a_irq_release: assert property ((!pen_touch_i) [*4] |-> !touch_irq_oe_o)
    else $error("touch still reported after release");
  a_irq_drain: assert property (!touch_irq_out_o)
    else $error("interrupt drives high");
  c_busy: cover property ($rose(busy_o));
  c_track: cover property ($fell(track_o));
  c_pen: cover property ($rose(touch_irq_oe_o));
endmodule : tadc_serial_port_monitor

bind tadc_serial_port tadc_serial_port_monitor u_tadc_serial_port_monitor (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .pen_touch_i(pen_touch_i),
  .shift_and_convert_clock_i(shift_and_convert_clock_i), .dout_o(dout_o),
  .dout_oe_o(dout_oe_o), .busy_o(busy_o), .busy_oe_o(busy_oe_o), .track_o(track_o),
  .touch_irq_out_o(touch_irq_out_o), .touch_irq_oe_o(touch_irq_oe_o));

// ==== tb_top.sv ====
// self-checking testbench of the touch digitizer serial port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] XV = 12'hA5C, YV = 12'h3E1, AV = 12'h7F2, BV = 12'hC0B;
  logic ref_clk = 1'h0, rst = 1'h1, pen = 1'h0;
  logic cs_n, sclk, din, dout, dout_oe, busy, busy_oe, irq, irq_oe, track;
  logic [11:0] res;
  int errors = 0, compares = 0;
  int busy_cyc = 0, track_cyc = 0; // ref cycles seen with busy or tracking high
  // one and three serial clocks of eight ref cycles each
  localparam logic [11:0] BUSY_LEN = 12'h008, TRACK_LEN = 12'h018;
  // running counts, read as differences around each frame
  always @(posedge ref_clk) begin
    busy_cyc  <= busy_cyc + ((busy === 1'h1) ? 1 : 0);
    track_cyc <= track_cyc + ((track === 1'h1) ? 1 : 0);
  end
  wire irq_line = irq_oe ? irq : 1'h1; // external pull-up
  always #50 ref_clk = ~ref_clk;
  tadc_host_model u_tadc_host_model (.ref_clk_i(ref_clk), .dout_i(dout), .dout_oe_i(dout_oe),
    .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  tadc_serial_port u_tadc_serial_port (.ref_clk_i(ref_clk), .rst_i(rst), .cs_n_i(cs_n),
    .shift_and_convert_clock_i(sclk), .din_i(din), .pen_touch_i(pen), .x_pos_i(XV),
    .y_pos_i(YV), .aux_input_a_i(AV), .aux_input_b_i(BV), .dout_o(dout),
    .dout_oe_o(dout_oe), .busy_o(busy), .busy_oe_o(busy_oe), .touch_irq_out_o(irq),
    .touch_irq_oe_o(irq_oe), .track_o(track));
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // each channel, differential and 8-bit modes and one invalid code, each frame in its own select
  task automatic t_channels();
    logic [6:0]  ctrl [8] = '{7'h14, 7'h54, 7'h24, 7'h64, 7'h60, 7'h10, 7'h1C, 7'h04};
    logic [11:0] exp  [8] = '{XV, YV, AV, BV, 12'h800, XV, XV & 12'hFF0, 12'h000};
    int          b0, t0;
    for (int k = 0; k < 8; k++) begin
      b0 = busy_cyc;
      t0 = track_cyc;
      u_tadc_host_model.xfer(ctrl[k], 24, res);
      check(res, exp[k], "channel result");
      check(12'(busy_cyc - b0), BUSY_LEN, "busy length");
      check(12'(track_cyc - t0), TRACK_LEN, "tracking length");
    end
  endtask : t_channels
  // abort after the first result bit, outputs float, next frame clean
  task automatic t_abort();
    u_tadc_host_model.xfer(7'h54, 10, res);
    check({11'h000, res[11]}, {11'h000, YV[11]}, "msb before abort");
    check({10'h000, dout_oe, busy_oe}, 12'h000, "released after abort");
    u_tadc_host_model.xfer(7'h14, 24, res);
    check(res, XV, "frame after abort");
  endtask : t_abort
  // pen touch pulls the shared line low, release lets the pull-up win
  task automatic t_pen();
    pen = 1'h1;
    repeat (5) @(posedge ref_clk);
    #1;
    check({11'h000, irq_line}, 12'h000, "touch line low");
    pen = 1'h0;
    repeat (5) @(posedge ref_clk);
    #1;
    check({11'h000, irq_line}, 12'h001, "touch line idle");
  endtask : t_pen
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    $display("MISMATCH %0t run did not finish", $time);
    results();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    t_channels();
    t_abort();
    t_pen();
    results();
  end
endmodule : tb_top
